// ### common/ort_map.vh
`ifndef ORT_MAP_VH
`define ORT_MAP_VH

// ----------------------------------------
// widths
// ----------------------------------------
`define ORT_DATA_W 8
`define ORT_MODE_W 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define ORT_STORE_RST 8'h00
`define ORT_DRIVE_RST 8'h00

// ----------------------------------------
// transfer modes (mode status output)
// ----------------------------------------
`define ORT_MODE_ISOLATE 3'h0
`define ORT_MODE_LIVE_B_TO_A 3'h1
`define ORT_MODE_STORED_B_TO_A 3'h2
`define ORT_MODE_LIVE_A_TO_B 3'h3
`define ORT_MODE_STORED_A_TO_B 3'h4

// ----------------------------------------
// control signal levels
// ----------------------------------------
`define ORT_DIR_DRIVE_A 1'b0
`define ORT_DIR_DRIVE_B 1'b1
`define ORT_SEL_LIVE 1'b0
`define ORT_SEL_STORED 1'b1

`endif

// ### src/ort_capture_reg.v
`timescale 1ns/1ns
`include "ort_map.vh"

module ort_capture_reg (
	// clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// capture strobe and data
	input wire capture_clock_in,
	input wire [`ORT_DATA_W-1:0] bus_lines_in,
	// stored word
	output reg [`ORT_DATA_W-1:0] store_q_out,
	output reg capture_seen_q_out
);

// ----------------------------------------
// edge detect
// ----------------------------------------
reg capture_clock_prev_q;
wire capture_rise;

assign capture_rise = capture_clock_in & ~capture_clock_prev_q;

always @(posedge clk_sys_in) begin
	if (rst_in) begin
		capture_clock_prev_q <= 1'b0;
	end else begin
		capture_clock_prev_q <= capture_clock_in;
	end
end

// ----------------------------------------
// storage
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (rst_in) begin
		store_q_out <= `ORT_STORE_RST;
		capture_seen_q_out <= 1'b0;
	end else begin
		capture_seen_q_out <= capture_rise;
		if (capture_rise) begin
			store_q_out <= bus_lines_in;
		end
	end
end

endmodule // ort_capture_reg

// ### src/ort_transceiver.v
`timescale 1ns/1ns
`include "ort_map.vh"

module ort_transceiver (
	// clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// output controls
	input wire output_enable_n_in,
	input wire direction_in,
	input wire a_to_b_source_select_in,
	input wire b_to_a_source_select_in,
	// capture clocks
	input wire a_to_b_capture_clock_in,
	input wire b_to_a_capture_clock_in,
	// port a
	input wire [`ORT_DATA_W-1:0] port_a_lines_in,
	output reg [`ORT_DATA_W-1:0] port_a_lines_out,
	output reg [`ORT_DATA_W-1:0] port_a_lines_oe_out,
	// port b
	input wire [`ORT_DATA_W-1:0] port_b_lines_in,
	output reg [`ORT_DATA_W-1:0] port_b_lines_out,
	output reg [`ORT_DATA_W-1:0] port_b_lines_oe_out,
	// status
	output wire [`ORT_DATA_W-1:0] a_side_store_out,
	output wire [`ORT_DATA_W-1:0] b_side_store_out,
	output wire a_capture_done_out,
	output wire b_capture_done_out,
	output reg [`ORT_MODE_W-1:0] transfer_mode_out
);

// ----------------------------------------
// mode decode
// ----------------------------------------
function [`ORT_MODE_W-1:0] decode_mode;
	input oe_n;
	input dir;
	input sel_ab;
	input sel_ba;
	begin
		if (oe_n) begin
			decode_mode = `ORT_MODE_ISOLATE;
		end else if (dir == `ORT_DIR_DRIVE_A) begin
			decode_mode = (sel_ba == `ORT_SEL_STORED) ?
				`ORT_MODE_STORED_B_TO_A : `ORT_MODE_LIVE_B_TO_A;
		end else begin
			decode_mode = (sel_ab == `ORT_SEL_STORED) ?
				`ORT_MODE_STORED_A_TO_B : `ORT_MODE_LIVE_A_TO_B;
		end
	end
endfunction

// ----------------------------------------
// drive decode
// ----------------------------------------
function drives_a;
	input [`ORT_MODE_W-1:0] mode;
	begin
		drives_a = (mode == `ORT_MODE_LIVE_B_TO_A) ||
			(mode == `ORT_MODE_STORED_B_TO_A);
	end
endfunction

function drives_b;
	input [`ORT_MODE_W-1:0] mode;
	begin
		drives_b = (mode == `ORT_MODE_LIVE_A_TO_B) ||
			(mode == `ORT_MODE_STORED_A_TO_B);
	end
endfunction

// ----------------------------------------
// mode select
// ----------------------------------------
wire [`ORT_MODE_W-1:0] mode_now;

assign mode_now = decode_mode(output_enable_n_in, direction_in,
	a_to_b_source_select_in, b_to_a_source_select_in);

// ----------------------------------------
// a side storage
// ----------------------------------------
// a side capture
ort_capture_reg u_a_store (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.capture_clock_in(a_to_b_capture_clock_in),
	.bus_lines_in(port_a_lines_in),
	.store_q_out(a_side_store_out),
	.capture_seen_q_out(a_capture_done_out)
);

// ----------------------------------------
// b side storage
// ----------------------------------------
// b side capture
ort_capture_reg u_b_store (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.capture_clock_in(b_to_a_capture_clock_in),
	.bus_lines_in(port_b_lines_in),
	.store_q_out(b_side_store_out),
	.capture_seen_q_out(b_capture_done_out)
);

// ----------------------------------------
// a side source
// ----------------------------------------
reg [`ORT_DATA_W-1:0] a_drive_d;

always @* begin
	a_drive_d = port_b_lines_in;
	if (b_to_a_source_select_in == `ORT_SEL_STORED) begin
		a_drive_d = b_side_store_out;
	end
end

// ----------------------------------------
// b side source
// ----------------------------------------
reg [`ORT_DATA_W-1:0] b_drive_d;

always @* begin
	b_drive_d = port_a_lines_in;
	if (a_to_b_source_select_in == `ORT_SEL_STORED) begin
		b_drive_d = a_side_store_out;
	end
end

// ----------------------------------------
// drive enables
// ----------------------------------------
wire en_a_d;
wire en_b_d;

assign en_a_d = drives_a(mode_now);
assign en_b_d = drives_b(mode_now);

// ----------------------------------------
// per-bit next values
// ----------------------------------------
wire [`ORT_DATA_W-1:0] a_pin_d;
wire [`ORT_DATA_W-1:0] a_oe_d;
wire [`ORT_DATA_W-1:0] b_pin_d;
wire [`ORT_DATA_W-1:0] b_oe_d;

genvar gi;
generate
	for (gi = 0; gi < `ORT_DATA_W; gi = gi + 1) begin : g_bit
		assign a_pin_d[gi] = en_a_d ? a_drive_d[gi] : 1'b0;
		assign a_oe_d[gi] = en_a_d;
		assign b_pin_d[gi] = en_b_d ? b_drive_d[gi] : 1'b0;
		assign b_oe_d[gi] = en_b_d;
	end
endgenerate

// ----------------------------------------
// port a pin registers
// ----------------------------------------
// a side drive
always @(posedge clk_sys_in) begin
	if (rst_in) begin
		port_a_lines_out <= `ORT_DRIVE_RST;
		port_a_lines_oe_out <= {`ORT_DATA_W{1'b0}};
	end else begin
		port_a_lines_out <= a_pin_d;
		port_a_lines_oe_out <= a_oe_d;
	end
end

// ----------------------------------------
// port b pin registers
// ----------------------------------------
// b side drive
always @(posedge clk_sys_in) begin
	if (rst_in) begin
		port_b_lines_out <= `ORT_DRIVE_RST;
		port_b_lines_oe_out <= {`ORT_DATA_W{1'b0}};
	end else begin
		port_b_lines_out <= b_pin_d;
		port_b_lines_oe_out <= b_oe_d;
	end
end

// ----------------------------------------
// mode status
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (rst_in) begin
		transfer_mode_out <= `ORT_MODE_ISOLATE;
	end else begin
		transfer_mode_out <= mode_now;
	end
end

endmodule // ort_transceiver

// ### testbench/ort_transceiver_asserts.sv
`timescale 1ns/1ns
`include "ort_map.vh"
module ort_transceiver_asserts (
	input wire clk_sys_in, rst_in, output_enable_n_in, direction_in,
	input wire a_to_b_source_select_in, b_to_a_source_select_in,
	input wire a_to_b_capture_clock_in, b_to_a_capture_clock_in,
	input wire [7:0] port_a_lines_in, port_b_lines_in, port_a_lines_out, port_b_lines_out,
	input wire [7:0] port_a_lines_oe_out, port_b_lines_oe_out, a_side_store_out, b_side_store_out,
	input wire a_capture_done_out, b_capture_done_out,
	input wire [2:0] transfer_mode_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence s_ba; !output_enable_n_in && !direction_in && !$rose(b_to_a_capture_clock_in);
	endsequence
	sequence s_ab; !output_enable_n_in && direction_in && !$rose(a_to_b_capture_clock_in);
	endsequence
	property p_st_a; $rose(a_to_b_capture_clock_in) |=> a_side_store_out == $past(port_a_lines_in);
	endproperty
	a_st_a: assert property (p_st_a) else $error("a store");
	property p_st_b; $rose(b_to_a_capture_clock_in) |=> b_side_store_out == $past(port_b_lines_in);
	endproperty
	a_st_b: assert property (p_st_b) else $error("b store");
	property p_excl; !(|port_a_lines_oe_out && |port_b_lines_oe_out); endproperty
	a_excl: assert property (p_excl) else $error("both driven");
	property p_iso; output_enable_n_in |=> !(|port_a_lines_oe_out) && !(|port_b_lines_oe_out)
		&& transfer_mode_out == `ORT_MODE_ISOLATE; endproperty
	a_iso: assert property (p_iso) else $error("isolate");
	property p_lba; s_ba ##0 !b_to_a_source_select_in |=> port_a_lines_oe_out == 8'hff
		&& port_a_lines_out == $past(port_b_lines_in)
		&& transfer_mode_out == `ORT_MODE_LIVE_B_TO_A; endproperty
	a_lba: assert property (p_lba) else $error("live to a");
	property p_sba; s_ba ##0 b_to_a_source_select_in |=> port_a_lines_oe_out == 8'hff
		&& port_a_lines_out == $past(b_side_store_out)
		&& transfer_mode_out == `ORT_MODE_STORED_B_TO_A; endproperty
	a_sba: assert property (p_sba) else $error("stored to a");
	property p_lab; s_ab ##0 !a_to_b_source_select_in |=> port_b_lines_oe_out == 8'hff
		&& port_b_lines_out == $past(port_a_lines_in)
		&& transfer_mode_out == `ORT_MODE_LIVE_A_TO_B; endproperty
	a_lab: assert property (p_lab) else $error("live to b");
	property p_sab; s_ab ##0 a_to_b_source_select_in |=> port_b_lines_oe_out == 8'hff
		&& port_b_lines_out == $past(a_side_store_out)
		&& transfer_mode_out == `ORT_MODE_STORED_A_TO_B; endproperty
	a_sab: assert property (p_sab) else $error("stored to b");
	sequence s_pulse_a; a_capture_done_out ##1 !a_capture_done_out;
	endsequence
	sequence s_pulse_b; b_capture_done_out ##1 !b_capture_done_out;
	endsequence
	property p_done_a; $rose(a_to_b_capture_clock_in) |=> s_pulse_a; endproperty
	a_done_a: assert property (p_done_a) else $error("a capture pulse");
	property p_done_b; $rose(b_to_a_capture_clock_in) |=> s_pulse_b; endproperty
	a_done_b: assert property (p_done_b) else $error("b capture pulse");
endmodule // ort_transceiver_asserts
bind ort_transceiver ort_transceiver_asserts ort_transceiver_asserts_i(.*);

// ### testbench/ort_bus_model.sv
`timescale 1ns/1ns
module ort_bus_model (
	input wire [7:0] ext_in, drv_in, oe_in,
	output wire [7:0] pin_out
);
	assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // ort_bus_model

// ### testbench/ort_transceiver_tb_top.sv
`timescale 1ns/1ns
`include "ort_map.vh"
module ort_transceiver_tb_top;
	reg clk_sys_in = 0, rst_in = 1, oe_n = 1, dir = 0, a_to_b_source_select = 0, b_to_a_source_select = 0, ca = 0, cb = 0;
	reg [7:0] ea = 8'h00, eb = 8'h00;
	wire [7:0] pa, pb, ao, bo, aoe, boe, ast, bst;
	wire adn, bdn;
	wire [2:0] mode;
	integer n_mismatch = 0, total_checks = 0;
	initial forever #20 clk_sys_in = ~clk_sys_in;
	ort_bus_model ort_bus_model_i(.ext_in(ea), .drv_in(ao), .oe_in(aoe), .pin_out(pa));
	ort_bus_model ort_bus_model_b_i(.ext_in(eb), .drv_in(bo), .oe_in(boe), .pin_out(pb));
	ort_transceiver ort_transceiver_i(.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.output_enable_n_in(oe_n), .direction_in(dir), .a_to_b_source_select_in(a_to_b_source_select),
		.b_to_a_source_select_in(b_to_a_source_select), .a_to_b_capture_clock_in(ca),
		.b_to_a_capture_clock_in(cb), .port_a_lines_in(pa), .port_a_lines_out(ao),
		.port_a_lines_oe_out(aoe), .port_b_lines_in(pb), .port_b_lines_out(bo),
		.port_b_lines_oe_out(boe), .a_side_store_out(ast), .b_side_store_out(bst),
		.a_capture_done_out(adn), .b_capture_done_out(bdn), .transfer_mode_out(mode));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task ctl(input [3:0] c, input [2:0] m);
		begin
			@(negedge clk_sys_in) {oe_n, dir, a_to_b_source_select, b_to_a_source_select} = c;
			@(negedge clk_sys_in);
			chk({5'h00, mode}, {5'h00, m});
		end
	endtask
	task cap(input [7:0] a, input [7:0] b, input xa, input xb);
		begin
			@(negedge clk_sys_in) {ea, eb, ca, cb} = {a, b, xa, xb};
			@(negedge clk_sys_in) {ca, cb} = 2'b00;
			chk({6'h00, adn, bdn}, {6'h00, xa, xb});
			@(negedge clk_sys_in);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task t_iso;
		begin
			ctl(4'b1000, `ORT_MODE_ISOLATE);
			cap(8'h5a, 8'ha5, 1'b1, 1'b1);
			chk(ast, 8'h5a);
			chk(bst, 8'ha5);
			chk(aoe | boe, 8'h00);
			$display("isolate done");
		end
	endtask
	task t_ba;
		begin
			ctl(4'b0000, `ORT_MODE_LIVE_B_TO_A);
			cap(8'h00, 8'h3c, 1'b0, 1'b0);
			chk(ao, 8'h3c);
			chk(aoe, 8'hff);
			chk(boe, 8'h00);
			ctl(4'b0001, `ORT_MODE_STORED_B_TO_A);
			chk(ao, 8'ha5);
			cap(8'h00, 8'h77, 1'b0, 1'b1);
			chk(ao, 8'h77);
			$display("b to a done");
		end
	endtask
	task t_ab;
		begin
			ctl(4'b0100, `ORT_MODE_LIVE_A_TO_B);
			cap(8'hc3, 8'h00, 1'b0, 1'b0);
			chk(bo, 8'hc3);
			chk(aoe, 8'h00);
			ctl(4'b0110, `ORT_MODE_STORED_A_TO_B);
			chk(bo, 8'h5a);
			cap(8'h81, 8'h00, 1'b1, 1'b0);
			chk(bo, 8'h81);
			$display("a to b done");
		end
	endtask
	initial begin
		#4000;
		n_mismatch = n_mismatch + 1;
		finish_test;
	end
	initial begin
		repeat (3) @(negedge clk_sys_in);
		rst_in = 0;
		t_iso;
		t_ba;
		t_ab;
		finish_test;
	end
endmodule // ort_transceiver_tb_top
